// file: inc/abtx_regs.svh
// register map, field positions and codes of the block-transmit host
// assumes byte addresses on a 32-bit ahb-lite bus, one word per register
`ifndef ABTX_REGS_SVH
`define ABTX_REGS_SVH
// controller registers (byte offsets, low address byte)
`define ABTX_A_CTRL   8'h00
`define ABTX_A_DEST   8'h04
`define ABTX_A_OFFLO  8'h08
`define ABTX_A_RSP    8'h0C
`define ABTX_A_BYTE   8'h10
`define ABTX_A_CMD    8'h14
`define ABTX_A_STAT   8'h18
`define ABTX_A_RDLEN  8'h1C
`define ABTX_A_LBLLO  8'h20
`define ABTX_A_LBLHI  8'h24
// command bits
`define ABTX_CMD_GO   0
`define ABTX_CMD_CLR  1
`define ABTX_CMD_REL  2
`define ABTX_CMD_LBL  8
// error bits inside the 5-bit error vector, status shifts it up by one
`define ABTX_E_SPD    0
`define ABTX_E_ALIGN  1
`define ABTX_E_RC     2
`define ABTX_E_LBL    3
`define ABTX_E_BUSY   4
// header quadlet fields
`define ABTX_Q0_SPD   16
`define ABTX_Q0_TL    10
`define ABTX_Q0_RT    8
`define ABTX_Q0_TC    4
`define ABTX_Q0_PRI   0
`define ABTX_Q1_RC    12
`define ABTX_HI       16
// transaction codes of block packets
`define ABTX_TC_WREQ  4'h1
`define ABTX_TC_WRSP  4'h2
`define ABTX_TC_RREQ  4'h5
`define ABTX_TC_RRSP  4'h7
// speed and response codes
`define ABTX_SPD_BAD  2'h3
`define ABTX_RC_OK    4'h0
`define ABTX_RC_CONF  4'h4
`define ABTX_RC_DATA  4'h5
`define ABTX_RC_TYPE  4'h6
`define ABTX_RC_ADDR  4'h7
// payload limits and sizes
`define ABTX_PAY_MAX  7'h40
`define ABTX_LANE0    5'h1F
`define ABTX_NQ_RSP   3'h3
`define ABTX_NQ_STD   3'h4
`endif

// file: inc/abtx_pkg.sv
// types of the block-transmit host: packet kinds, states, state record
// assumes nothing beyond the register header for the numbers
package abtx_pkg;
    typedef enum logic [1:0] {
        ABTX_WREQ, ABTX_RREQ, ABTX_WRSP, ABTX_RRSP
    } abtx_ptype_t;
    typedef enum logic [1:0] {
        ABTX_RT_NEW, ABTX_RT_X, ABTX_RT_A, ABTX_RT_B
    } abtx_rt_t;
    typedef enum logic {ABTX_IDLE, ABTX_SEND} abtx_state_t;
    typedef struct packed {
        abtx_state_t       st;
        abtx_ptype_t       ptype;
        abtx_ptype_t       sp;
        logic [1:0]        spd;
        abtx_rt_t          rt;
        logic [9:0]        bus;
        logic [5:0]        node;
        logic [15:0]       offhi;
        logic [31:0]       offlo;
        logic [15:0]       xt;
        logic [5:0]        rsplab;
        logic [3:0]        rcode;
        logic [15:0]       rdlen;
        logic [15:0][31:0] pay;
        logic [6:0]        cnt;
        logic [63:0]       lbl_busy;
        logic [5:0]        lbl;
        logic [4:0]        err;
        logic [3:0][31:0]  hdr;
        logic [2:0]        nq;
        logic [4:0]        tot;
        logic [4:0]        idx;
        logic [4:0]        oidx;
        logic              a_wr;
        logic [7:0]        a_adr;
        logic              rdy;
        logic [31:0]       rdata;
        logic              f_wr;
        logic [31:0]       f_data;
        logic              f_first;
        logic              f_last;
    } abtx_st_t;
endpackage

// file: hw/abtx_sync2.sv
// two-stage synchroniser for one level from outside the clock domain
// assumes the level stays for at least two clock periods
`timescale 1ns/100ps
`default_nettype none
module abtx_sync2 (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // level in and out
    input  wire logic d,
    output logic      q
);
    logic [1:0] s_reg;
    logic [1:0] s_next;

    always_comb begin
        s_next = {s_reg[0], d};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= 2'h0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg[1];
endmodule
`default_nettype wire

// file: hw/abtx_host.sv
// host controller that builds block-transmit packets into the link fifo
// assumes ahb-lite single word transfers and a fifo full flag with margin
//
// Summary of operation
// - speed code in every packet; code 11 is refused, never sent.
// - requests get a unique free label; responses reuse the request's.
// - retry field encodes new, retry_X, retryA, retryB as 00..11.
// - transaction code chosen from the packet kind per the standard.
// - priority bits always written as zero for cable systems.
// - destination id is 10-bit bus number then 6-bit node number.
// - response codes 0, 5, 6, 7 accepted; reserved codes refused.
// - response code 4 means conflict; it is accepted for sending.
// - request offset must be quadlet aligned, else packet refused.
// - length field equals the payload bytes carried; a read request gives the bytes asked for.
// - zero length means no payload quadlets follow the header.
// - first payload byte lands in byte lane 0 of first quadlet.
// - request quadlet four holds length high, extended code low.
// - read response: id and code in quadlet two, quadlet three zero.
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`include "abtx_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module abtx_host (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // link transmit fifo
    input  wire logic        dev_fifo_full,
    output logic             dev_fifo_wr,
    output logic [31:0]      dev_fifo_data,
    output logic             dev_fifo_first,
    output logic             dev_fifo_last
);
    abtx_pkg::abtx_st_t s_reg;
    abtx_pkg::abtx_st_t s_next;
    logic               full_s;
    logic [31:0]        wd;
    logic               req;
    logic [6:0]         freel;
    logic [4:0]         e;
    logic               launch;
    logic [15:0]        len;
    logic [4:0]         npay;
    logic [4:0]         pos;

    // lowest free label, msb flags that one was found
    function automatic logic [6:0] free_lbl(input logic [63:0] b);
        logic [6:0] r;
        r = 7'h00;
        for (int i = 63; i >= 0; i--) begin
            if (!b[i]) begin
                r = {1'b1, 6'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] tc_of(input abtx_pkg::abtx_ptype_t p);
        case (p)
            abtx_pkg::ABTX_WREQ: tc_of = `ABTX_TC_WREQ;
            abtx_pkg::ABTX_RREQ: tc_of = `ABTX_TC_RREQ;
            abtx_pkg::ABTX_WRSP: tc_of = `ABTX_TC_WRSP;
            default:             tc_of = `ABTX_TC_RRSP;
        endcase
    endfunction

    function automatic logic rc_ok(input logic [3:0] c);
        rc_ok = (c == `ABTX_RC_OK) || (c == `ABTX_RC_CONF) ||
                (c == `ABTX_RC_DATA) || (c == `ABTX_RC_TYPE) ||
                (c == `ABTX_RC_ADDR);
    endfunction

    function automatic logic is_req(input abtx_pkg::abtx_ptype_t p);
        is_req = (p == abtx_pkg::ABTX_WREQ) || (p == abtx_pkg::ABTX_RREQ);
    endfunction

    abtx_sync2 u_full (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       (dev_fifo_full),
        .q       (full_s)
    );

    always_comb begin
        s_next = s_reg;
        wd = hwdata;
        req = is_req(s_reg.ptype);
        freel = free_lbl(s_reg.lbl_busy);
        e = 5'h00;
        launch = 1'b0;
        len = 16'h0000;
        npay = 5'h00;
        pos = `ABTX_LANE0 - {s_reg.cnt[1:0], 3'h0};
        s_next.f_wr = 1'b0;
        s_next.a_wr = 1'b0;
        s_next.rdy = 1'b1;
        // address phase: reads are answered from state in the next cycle
        if (hsel && htrans[1] && hready) begin
            s_next.a_wr = hwrite;
            s_next.a_adr = haddr[7:0];
            s_next.rdata = 32'h0000_0000;
            if (!hwrite) begin
                case (haddr[7:0])
                    `ABTX_A_CTRL:  s_next.rdata = {26'h0, s_reg.rt,
                                                   s_reg.spd, s_reg.ptype};
                    `ABTX_A_DEST:  s_next.rdata = {s_reg.offhi, s_reg.bus,
                                                   s_reg.node};
                    `ABTX_A_OFFLO: s_next.rdata = s_reg.offlo;
                    `ABTX_A_RSP:   s_next.rdata = {4'h0, s_reg.rcode, 2'h0,
                                                   s_reg.rsplab, s_reg.xt};
                    `ABTX_A_BYTE:  s_next.rdata = {25'h0, s_reg.cnt};
                    `ABTX_A_STAT:  s_next.rdata = {9'h0, s_reg.cnt, 2'h0,
                                                   s_reg.lbl, 2'h0, s_reg.err,
                                                   s_reg.st == abtx_pkg::ABTX_SEND};
                    `ABTX_A_RDLEN: s_next.rdata = {16'h0, s_reg.rdlen};
                    `ABTX_A_LBLLO: s_next.rdata = s_reg.lbl_busy[31:0];
                    `ABTX_A_LBLHI: s_next.rdata = s_reg.lbl_busy[63:32];
                    default:       s_next.rdata = 32'h0000_0000;
                endcase
            end
        end
        // data phase of a write
        if (s_reg.a_wr) begin
            case (s_reg.a_adr)
                `ABTX_A_CTRL: begin
                    s_next.ptype = abtx_pkg::abtx_ptype_t'(wd[1:0]);
                    s_next.spd = wd[3:2];
                    s_next.rt = abtx_pkg::abtx_rt_t'(wd[5:4]);
                end
                `ABTX_A_DEST: begin
                    s_next.node = wd[5:0];
                    s_next.bus = wd[15:6];
                    s_next.offhi = wd[31:16];
                end
                `ABTX_A_OFFLO: s_next.offlo = wd;
                `ABTX_A_RSP: begin
                    s_next.xt = wd[15:0];
                    s_next.rsplab = wd[21:16];
                    s_next.rcode = wd[27:24];
                end
                `ABTX_A_RDLEN: s_next.rdlen = wd[15:0];
                `ABTX_A_STAT: s_next.err = s_reg.err & ~wd[5:1];
                `ABTX_A_BYTE: begin
                    // bytes pack from lane 0 upward, the stream never shifts
                    if (s_reg.st == abtx_pkg::ABTX_IDLE &&
                        s_reg.cnt < `ABTX_PAY_MAX) begin
                        s_next.pay[s_reg.cnt[5:2]][pos -: 8] = wd[7:0];
                        s_next.cnt = s_reg.cnt + 7'h01;
                    end
                end
                `ABTX_A_CMD: begin
                    if (wd[`ABTX_CMD_REL]) begin
                        s_next.lbl_busy[wd[`ABTX_CMD_LBL +: 6]] = 1'b0;
                    end
                    if (wd[`ABTX_CMD_CLR] &&
                        s_reg.st == abtx_pkg::ABTX_IDLE) begin
                        s_next.pay = '0;
                        s_next.cnt = 7'h00;
                    end
                    if (wd[`ABTX_CMD_GO]) begin
                        e[`ABTX_E_SPD] = s_reg.spd == `ABTX_SPD_BAD;
                        e[`ABTX_E_ALIGN] = req &&
                                           s_reg.offlo[1:0] != 2'h0;
                        // conflict code 4 passes like the other legal codes
                        e[`ABTX_E_RC] = !req && !rc_ok(s_reg.rcode);
                        e[`ABTX_E_LBL] = req && !freel[6];
                        e[`ABTX_E_BUSY] = s_reg.st == abtx_pkg::ABTX_SEND;
                        s_next.err = s_next.err | e;
                        launch = e == 5'h00;
                    end
                end
                default: s_next.err = s_next.err;
            endcase
        end
        if (launch) begin
            s_next.sp = s_reg.ptype;
            s_next.lbl = req ? freel[5:0] : s_reg.rsplab;
            if (req) begin
                s_next.lbl_busy[freel[5:0]] = 1'b1;
            end
            // read requests ask for bytes, the others carry what was written
            len = (s_reg.ptype == abtx_pkg::ABTX_RREQ) ?
                  s_reg.rdlen : {9'h0, s_reg.cnt};
            if (s_reg.ptype == abtx_pkg::ABTX_WREQ ||
                s_reg.ptype == abtx_pkg::ABTX_RRSP) begin
                npay = 5'((s_reg.cnt + 7'h03) >> 2);
            end
            s_next.hdr[0] = (32'(s_reg.spd) << `ABTX_Q0_SPD) |
                            (32'(s_next.lbl) << `ABTX_Q0_TL) |
                            (32'(s_reg.rt) << `ABTX_Q0_RT) |
                            (32'(tc_of(s_reg.ptype)) << `ABTX_Q0_TC);
            if (req) begin
                s_next.hdr[1] = {s_reg.bus, s_reg.node, s_reg.offhi};
                s_next.hdr[2] = s_reg.offlo;
            end else begin
                s_next.hdr[1] = {s_reg.bus, s_reg.node, 16'h0} |
                                (32'(s_reg.rcode) << `ABTX_Q1_RC);
                s_next.hdr[2] = 32'h0000_0000;
            end
            s_next.hdr[3] = {len, s_reg.xt};
            s_next.nq = (s_reg.ptype == abtx_pkg::ABTX_WRSP) ?
                        `ABTX_NQ_RSP : `ABTX_NQ_STD;
            s_next.tot = 5'(s_next.nq) + npay;
            s_next.idx = 5'h00;
            s_next.st = abtx_pkg::ABTX_SEND;
        end
        case (s_reg.st)
            abtx_pkg::ABTX_IDLE: s_next.f_wr = 1'b0;
            abtx_pkg::ABTX_SEND: begin
                // full is two cycles old, the fifo must flag it with margin
                if (!full_s) begin
                    s_next.f_wr = 1'b1;
                    s_next.f_data = (s_reg.idx < 5'(s_reg.nq)) ?
                        s_reg.hdr[s_reg.idx[1:0]] :
                        s_reg.pay[4'(s_reg.idx - 5'(s_reg.nq))];
                    s_next.f_first = s_reg.idx == 5'h00;
                    s_next.f_last = s_reg.idx == s_reg.tot - 5'h01;
                    s_next.oidx = s_reg.idx;
                    s_next.idx = s_reg.idx + 5'h01;
                    if (s_next.f_last) begin
                        // zeroed payload keeps the pad bytes of later packets clean
                        s_next.st = abtx_pkg::ABTX_IDLE;
                        s_next.pay = '0;
                        s_next.cnt = 7'h00;
                    end
                end
            end
            default: s_next.st = abtx_pkg::ABTX_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign hreadyout = s_reg.rdy;
    assign hresp = 1'b0 & s_reg.rdy;
    assign hrdata = s_reg.rdata;
    assign dev_fifo_wr = s_reg.f_wr;
    assign dev_fifo_data = s_reg.f_data;
    assign dev_fifo_first = s_reg.f_first;
    assign dev_fifo_last = s_reg.f_last;

    spd_ok_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        dev_fifo_wr && dev_fifo_first |->
            dev_fifo_data[`ABTX_Q0_SPD +: 2] != `ABTX_SPD_BAD)
        else $error("undefined speed code sent");
    lbl_alloc_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        launch && req |-> !s_reg.lbl_busy[freel[5:0]]
            ##1 s_reg.lbl_busy[s_reg.lbl])
        else $error("request label not unique or not held");
    tcode_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        dev_fifo_wr && dev_fifo_first |->
            dev_fifo_data[`ABTX_Q0_TC +: 4] == tc_of(s_reg.sp))
        else $error("transaction code does not match kind");
    prio_zero_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        dev_fifo_wr && dev_fifo_first |->
            dev_fifo_data[`ABTX_Q0_PRI +: 4] == 4'h0)
        else $error("priority not zero");
    rcode_ok_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        dev_fifo_wr && s_reg.oidx == 5'h01 && !is_req(s_reg.sp) |->
            rc_ok(dev_fifo_data[`ABTX_Q1_RC +: 4]))
        else $error("reserved response code sent");
    align_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        dev_fifo_wr && s_reg.oidx == 5'h02 && is_req(s_reg.sp) |->
            dev_fifo_data[1:0] == 2'h0)
        else $error("offset not quadlet aligned");
    len_zero_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        dev_fifo_wr && s_reg.oidx == 5'h03 &&
        s_reg.sp != abtx_pkg::ABTX_RREQ &&
        dev_fifo_data[31:16] == 16'h0 |-> dev_fifo_last)
        else $error("payload follows a zero length");
    len_field_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        launch && s_reg.ptype == abtx_pkg::ABTX_WREQ |=>
            s_reg.hdr[3][31:16] == {9'h0, $past(s_reg.cnt)} &&
            s_reg.tot == 5'h04 + 5'(($past(s_reg.cnt) + 7'h03) >> 2))
        else $error("length field or quadlet count wrong");
    lane0_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_reg.a_wr && s_reg.a_adr == `ABTX_A_BYTE && s_reg.cnt == 7'h00 &&
        s_reg.st == abtx_pkg::ABTX_IDLE |=>
            s_reg.pay[0][31:24] == $past(hwdata[7:0]) && s_reg.cnt == 7'h01)
        else $error("first byte not in lane 0");
    q3_resv_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        dev_fifo_wr && s_reg.oidx == 5'h02 &&
        s_reg.sp == abtx_pkg::ABTX_RRSP |-> dev_fifo_data == 32'h0)
        else $error("reserved quadlet not zero");
    rreq_nopay_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        dev_fifo_wr && s_reg.oidx == 5'h03 &&
        s_reg.sp == abtx_pkg::ABTX_RREQ |-> dev_fifo_last)
        else $error("read request carries payload");
    wrsp_end_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        dev_fifo_wr && s_reg.oidx == 5'h02 &&
        s_reg.sp == abtx_pkg::ABTX_WRSP |-> dev_fifo_last)
        else $error("write response longer than three");
    end_clean_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        dev_fifo_wr && dev_fifo_last |->
            s_reg.st == abtx_pkg::ABTX_IDLE && s_reg.cnt == 7'h00)
        else $error("payload not cleared at packet end");
    rsp_label_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        dev_fifo_wr && dev_fifo_first && !is_req(s_reg.sp) |->
            dev_fifo_data[`ABTX_Q0_TL +: 6] == s_reg.lbl)
        else $error("response label not the one given");
    byte_cap_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_reg.cnt <= `ABTX_PAY_MAX)
        else $error("payload count past its limit");
    first_q_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        dev_fifo_wr && dev_fifo_first |->
            s_reg.oidx == 5'h00 && !dev_fifo_last)
        else $error("header start misplaced");
endmodule
`default_nettype wire

// file: tb/abtx_fifo_model.sv
// behavioural device end of the link transmit fifo, sinks each packet
// assumes one quadlet per write pulse, sampled on the rising clock edge
`timescale 1ns/100ps
`default_nettype none
module abtx_fifo_model (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // fifo write side
    input  wire logic        dev_fifo_wr,
    input  wire logic [31:0] dev_fifo_data,
    input  wire logic        dev_fifo_first,
    input  wire logic        dev_fifo_last,
    output logic             dev_fifo_full,
    // stall request from the bench
    input  wire logic        slow
);
    logic [31:0] got[$];
    logic [2:0]  ph;
    int          pkts;
    int          rate;
    int          nbytes;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph            <= 3'h0;
            dev_fifo_full <= 1'b0;
            pkts          <= 0;
        end else begin
            ph <= (ph == 3'h4) ? 3'h0 : ph + 3'h1;
            // full comes early: the host still lands a few quadlets after it
            dev_fifo_full <= slow && (ph < 3'h2);
            if (dev_fifo_wr) begin
                if (dev_fifo_first) got.delete();
                got.push_back(dev_fifo_data);
                if (dev_fifo_last) begin
                    // line rate picked from the speed field
                    rate <= got[0][17:16] == 2'h0 ? 100 :
                            got[0][17:16] == 2'h1 ? 200 : 400;
                    // only length bytes go out, pad lanes dropped
                    nbytes <= (got.size() > 3 && (got[0][7:4] == 4'h1 ||
                              got[0][7:4] == 4'h7)) ? int'(got[3][31:16]) : 0;
                    pkts <= pkts + 1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/async_block_tx_packet_format_tb.sv
// self-checking bench of the block-transmit host controller
// assumes the fifo model beside it and acts as the only ahb-lite master
`include "abtx_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module async_block_tx_packet_format_tb;
    logic             hclk;
    logic             hresetn;
    logic             hsel;
    logic [31:0]      haddr;
    logic [1:0]       htrans;
    logic             hwrite;
    logic [2:0]       hsize;
    logic [31:0]      hwdata;
    logic             slow;
    wire logic        hready;
    wire logic        hresp;
    wire logic [31:0] hrdata;
    wire logic        f_wr;
    wire logic [31:0] f_data;
    wire logic        f_first;
    wire logic        f_last;
    wire logic        f_full;
    logic [31:0]      seed;
    logic [63:0]      busy;
    logic [31:0]      r;
    int               bad_count;
    int               n_tests;

    abtx_host u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .dev_fifo_full(f_full), .dev_fifo_wr(f_wr),
        .dev_fifo_data(f_data), .dev_fifo_first(f_first),
        .dev_fifo_last(f_last));
    abtx_fifo_model u_fifo (.hclk(hclk), .hresetn(hresetn),
        .dev_fifo_wr(f_wr), .dev_fifo_data(f_data), .dev_fifo_first(f_first),
        .dev_fifo_last(f_last), .dev_fifo_full(f_full), .slow(slow));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // entered right after a rising edge; waits on hready with no count
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        // one idle cycle follows each write before the next transfer starts
        if (w) @(posedge hclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        ahb(1'b0, a, 32'h0, q);
    endtask

    task automatic send(input logic [1:0] k, input int nb,
                        input logic [3:0] rc, input bit dbl);
        logic [31:0] e[$];
        logic [31:0] d, off, rsp, rdl, q;
        logic [7:0]  b[64];
        logic [3:0]  tc[4];
        logic [1:0]  spd, rt;
        logic [5:0]  lbl;
        int          n, p0, len;
        tc  = '{4'h1, 4'h5, 4'h2, 4'h7};
        q   = rnd();
        spd = 2'(q % 3);
        rt  = q[5:4];
        d   = rnd();
        off = rnd() & 32'hFFFFFFFC;
        q   = rnd();
        rsp = {4'h0, rc, 2'h0, q[21:0]};
        rdl = rnd() & 32'h0000FFFF;
        wr(`ABTX_A_CTRL, {26'h0, rt, spd, k});
        wr(`ABTX_A_DEST, d);
        wr(`ABTX_A_OFFLO, off);
        wr(`ABTX_A_RSP, rsp);
        wr(`ABTX_A_RDLEN, rdl);
        n = 0;
        if (k == 2'h0 || k == 2'h3) begin
            for (int i = 0; i < nb; i++) begin
                q = rnd();
                if (i < 64) b[i] = q[7:0];
                wr(`ABTX_A_BYTE, q);
            end
            n = nb > 64 ? 64 : nb;
        end
        rd(`ABTX_A_BYTE, q);
        check(q & 32'h7F, n);
        if (k < 2'h2) begin
            lbl = 6'h0;
            while (busy[lbl]) lbl++;
            busy[lbl] = 1'b1;
        end else lbl = rsp[21:16];
        q = rnd();
        slow <= q[0];
        p0 = u_fifo.pkts;
        wr(`ABTX_A_CMD, 32'h1);
        if (dbl) wr(`ABTX_A_CMD, 32'h1);
        while (u_fifo.pkts == p0) @(posedge hclk);
        len = k == 2'h1 ? int'(rdl) : n;
        e.push_back({14'h0, spd, lbl, rt, tc[k], 4'h0});
        e.push_back(k < 2'h2 ? {d[15:0], d[31:16]} : {d[15:0], rc, 12'h0});
        e.push_back(k < 2'h2 ? off : 32'h0);
        if (k != 2'h2) e.push_back({len[15:0], rsp[15:0]});
        for (int i = 0; i < (n + 3) / 4; i++) begin
            q = 32'h0;
            for (int j = 0; j < 4; j++)
                if (4 * i + j < n) q[31 - 8 * j -: 8] = b[4 * i + j];
            e.push_back(q);
        end
        check(u_fifo.got.size(), e.size());
        foreach (e[i]) check(u_fifo.got[i], e[i]);
        check(u_fifo.rate, spd == 2'h0 ? 100 : spd == 2'h1 ? 200 : 400);
        check(u_fifo.nbytes, n);
        do rd(`ABTX_A_STAT, q); while (q[0] !== 1'b0);
        check(q & 32'h007F003E, dbl ? 32'h20 : 32'h0);
        if (k < 2'h2) check({26'h0, q[13:8]}, {26'h0, lbl});
        if (dbl) wr(`ABTX_A_STAT, 32'h3E);
    endtask

    // a refused go sets only the named error and sends nothing
    task automatic refuse(input logic [31:0] ctl, input logic [31:0] off,
                          input logic [31:0] rsp, input logic [31:0] bits);
        logic [31:0] q;
        int          p0;
        p0 = u_fifo.pkts;
        wr(`ABTX_A_CTRL, ctl);
        wr(`ABTX_A_OFFLO, off);
        wr(`ABTX_A_RSP, rsp);
        wr(`ABTX_A_CMD, 32'h1);
        rd(`ABTX_A_STAT, q);
        check(q & 32'h3F, bits);
        check(u_fifo.pkts, p0);
        wr(`ABTX_A_STAT, 32'h3E);
        rd(`ABTX_A_STAT, q);
        check(q & 32'h3E, 32'h0);
    endtask

    initial begin
        #2000000;
        bad_count++;
        results();
    end

    initial begin
        logic [3:0] rcs[5];
        rcs       = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7};
        seed      = 32'h1861CA6E;
        busy      = 64'h0;
        bad_count = 0;
        n_tests   = 0;
        hresetn   = 1'b0;
        hsel      = 1'b0;
        haddr     = 32'h0;
        htrans    = 2'h0;
        hwrite    = 1'b0;
        hsize     = 3'h2;
        hwdata    = 32'h0;
        slow      = 1'b0;
        repeat (20) @(posedge hclk);
        check({31'h0, hready}, 32'h0);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        check({30'h0, hresp, hready}, 32'h1);
        rd(`ABTX_A_STAT, r);
        check(r, 32'h0);
        rd(8'h40, r);
        check(r, 32'h0);
        rd(`ABTX_A_CTRL, r);
        check(r, 32'h0);
        // every kind, retry code and valid response code, 64-byte cap first
        for (int i = 0; i < 24; i++)
            send(2'(i % 4), i == 0 ? 65 : i == 4 ? 0 : int'(rnd() % 13),
                 rcs[i % 5], 1'b0);
        wr(`ABTX_A_CMD, 32'h4);
        busy[0] = 1'b0;
        send(2'h0, 5, 4'h0, 1'b0);
        rd(`ABTX_A_LBLLO, r);
        check(r, busy[31:0]);
        rd(`ABTX_A_LBLHI, r);
        check(r, busy[63:32]);
        wr(`ABTX_A_BYTE, 32'h5A);
        wr(`ABTX_A_CMD, 32'h2);
        rd(`ABTX_A_BYTE, r);
        check(r, 32'h0);
        send(2'h3, 9, 4'h4, 1'b1);
        refuse(32'h0C, 32'h0, 32'h0, 32'h02);
        refuse(32'h01, 32'h2, 32'h0, 32'h04);
        for (int c = 1; c < 16; c++)
            if (c < 4 || c > 7) refuse(32'h2, 32'h0, c << 24, 32'h08);
        results();
    end
endmodule
`default_nettype wire
